//--- pkg/dbgme_pkg.sv
// Package of constants and types for the debug entry and trace control block.
package dbgme_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int HOLD_TIME_NS = 50;
   localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // Register map, indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [9:0] REG_CTRL_IDX = 10'h020;
   localparam logic [9:0] REG_STAT_IDX = 10'h021;
   localparam logic [9:0] REG_TRACE_IDX = 10'h022;
   localparam int CTRL_ARM_BIT = 0;
   localparam int STAT_ARM_BIT = 3;
   localparam int TRC_HIGH_LSB = 6;
   localparam int TRC_LOW_WIDTH = 6;
   localparam logic [7:0] TRACE_RST = 8'h00;
   localparam int STAT_ENABLE_BIT = 7;
   localparam int STAT_ACTIVE_BIT = 6;
   localparam logic [3:0] DBG_STATUS_OFF = 4'h1;
   // ----------------------------------------------------------------
   // Global map window
   // ----------------------------------------------------------------
   localparam logic [22:0] DBG_WIN_BASE = 23'h7fff00;
   localparam logic [22:0] DBG_REG_LAST = 23'h7fff0b;
   // ----------------------------------------------------------------
   // Sequencer flag codes and host commands
   // ----------------------------------------------------------------
   localparam logic [2:0] SEQ_DISARMED = 3'h0;
   localparam logic [2:0] SEQ_STATE1 = 3'h1;
   localparam logic [2:0] SEQ_STATE3 = 3'h3;
   localparam logic [2:0] SEQ_FINAL = 3'h4;
   localparam logic [1:0] CMD_WRITE_STATUS = 2'h1;
   localparam logic [1:0] CMD_BACKGROUND = 2'h2;
   typedef struct packed {
      logic valid;
      logic [1:0] kind;
      logic [7:0] data;
   } dbgme_cmd_t;
   typedef struct packed {
      logic reserved;
      logic source;
      logic [1:0] range;
      logic [1:0] mode;
      logic [1:0] align;
   } dbgme_trace_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_ACTIVE = 4'b0100,
      ST_HOLD = 4'b1000
   } dbgme_state_t;
endpackage

//--- rtl/dbgme_core.sv
// Debug mode entry control, debug window decode and trace control register.
//
// Register access over Wishbone was decided locally.
module dbgme_core #(
   parameter logic [1:0] MODE_NORMAL = 2'h0,
   parameter logic [1:0] MODE_SUPPRESS = 2'h1,
   parameter logic [1:0] MODE_DETAIL = 2'h2,
   parameter logic [1:0] ALIGN_BEGIN = 2'h0,
   parameter logic [1:0] ALIGN_MIDDLE = 2'h2,
   parameter logic [1:0] ALIGN_END = 2'h1
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Wishbone slave.
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [9:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatIn,
   output logic [31:0] wbDatOut,
   output logic wbAck,
   // Host single-wire command and chip state.
   input wire dbgme_pkg::dbgme_cmd_t hostCmd,
   input wire logic specialChip,
   input wire logic secured,
   // Processor activation sources and boundary.
   input wire logic cpuEnterDbg,
   input wire logic extTag,
   input wire logic bkptTag,
   input wire logic bkptForce,
   input wire logic instrDone,
   input wire logic dbgExit,
   output logic cpuHold,
   output logic fwFetchStart,
   output logic debugActive,
   output logic debugEnable,
   // Firmware commands and debug register reads.
   input wire logic fwCmdValid,
   output logic fwCmdAccept,
   input wire logic [3:0] dbgRdAddr,
   output logic [7:0] dbgRdData,
   // Global map decode.
   input wire logic [22:0] cpuAddr,
   output logic regWindowHit,
   output logic tableHit,
   // Trace and sequencer.
   input wire logic seqTrigger,
   input wire logic cmpHit,
   input wire logic compareEnable,
   output dbgme_pkg::dbgme_trace_t traceCfg,
   output logic modeNormal,
   output logic modeSuppress,
   output logic modeDetail,
   output logic alignBegin,
   output logic alignMiddle,
   output logic alignEnd,
   output logic cmpSeqTrigger,
   output logic [2:0] seqState
);
   import dbgme_pkg::*;

   // ----------------------------------------------------------------
   // Entry state machine
   // ----------------------------------------------------------------
   dbgme_state_t state_r, state_nxt;
   logic [1:0] boundLeft_r, boundLeft_nxt;
   logic [3:0] holdCnt_r, holdCnt_nxt;
   logic enable_r, enable_nxt;
   logic startup_r;
   logic fwStart_nxt;
   logic cpuReq;
   logic hostBg;

   assign hostBg = hostCmd.valid && (hostCmd.kind == CMD_BACKGROUND);
   assign cpuReq = cpuEnterDbg | extTag | bkptTag | bkptForce;

   always_comb begin
      state_nxt = state_r;
      boundLeft_nxt = boundLeft_r;
      holdCnt_nxt = holdCnt_r;
      enable_nxt = enable_r;
      fwStart_nxt = 1'b0;
      if (hostCmd.valid && (hostCmd.kind == CMD_WRITE_STATUS)) begin
         enable_nxt = hostCmd.data[STAT_ENABLE_BIT];
      end
      case (state_r)
         ST_IDLE: begin
            if (startup_r && specialChip) begin
               enable_nxt = 1'b1;
               state_nxt = ST_ACTIVE;
               fwStart_nxt = 1'b1;
            end else if (enable_r && (cpuReq || hostBg)) begin
               state_nxt = ST_WAIT;
               boundLeft_nxt = bkptForce ? 2'h2 : 2'h1;
            end else if (!enable_r && cpuReq) begin
               state_nxt = ST_HOLD;
               holdCnt_nxt = 4'(HOLD_CYCLES - 1);
            end
         end
         ST_WAIT: begin
            if (instrDone) begin
               if (boundLeft_r == 2'h1) begin
                  state_nxt = ST_ACTIVE;
                  fwStart_nxt = 1'b1;
               end else begin
                  boundLeft_nxt = boundLeft_r - 2'h1;
               end
            end
         end
         ST_ACTIVE: begin
            if (dbgExit) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_HOLD: begin
            if (holdCnt_r == 4'h0) begin
               state_nxt = ST_IDLE;
            end else begin
               holdCnt_nxt = holdCnt_r - 4'h1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         boundLeft_r <= 2'h0;
         holdCnt_r <= 4'h0;
         enable_r <= 1'b0;
         startup_r <= 1'b1;
         cpuHold <= 1'b0;
         fwFetchStart <= 1'b0;
         debugActive <= 1'b0;
      end else begin
         state_r <= state_nxt;
         boundLeft_r <= boundLeft_nxt;
         holdCnt_r <= holdCnt_nxt;
         enable_r <= enable_nxt;
         startup_r <= 1'b0;
         cpuHold <= (state_nxt == ST_HOLD);
         fwFetchStart <= fwStart_nxt;
         debugActive <= (state_nxt == ST_ACTIVE);
      end
   end
   assign debugEnable = enable_r;

   // ----------------------------------------------------------------
   // Firmware commands, debug reads and map decode
   // ----------------------------------------------------------------
   logic [7:0] dbgStatus;
   assign dbgStatus = {enable_r, debugActive, 6'h00};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fwCmdAccept <= 1'b0;
         dbgRdData <= 8'h00;
         regWindowHit <= 1'b0;
         tableHit <= 1'b0;
      end else begin
         fwCmdAccept <= fwCmdValid && debugActive;
         dbgRdData <= (dbgRdAddr == DBG_STATUS_OFF) ? dbgStatus : 8'h00;
         regWindowHit <= debugActive && (cpuAddr >= DBG_WIN_BASE) &&
                         (cpuAddr <= DBG_REG_LAST);
         tableHit <= debugActive && (cpuAddr > DBG_REG_LAST);
      end
   end

   // ----------------------------------------------------------------
   // Wishbone registers, trace control and sequencer
   // ----------------------------------------------------------------
   dbgme_trace_t trace_r, trace_nxt;
   logic armed_r, armed_nxt;
   logic [2:0] seq_r, seq_nxt;
   logic [31:0] wbDat_nxt;
   logic wbAck_nxt;
   logic wbReq;
   logic wbWr;
   logic seqStep;

   assign wbReq = wbCyc && wbStb && !wbAck;
   assign wbWr = wbReq && wbWe && wbSel[0];
   assign seqStep = seqTrigger || (cmpHit && compareEnable);

   always_comb begin
      trace_nxt = trace_r;
      armed_nxt = armed_r;
      seq_nxt = seq_r;
      wbDat_nxt = 32'h0000_0000;
      wbAck_nxt = wbReq;
      if (wbWr && (wbAdr == {REG_TRACE_IDX[7:0], 2'b00})) begin
         if (!secured && !armed_r) begin
            trace_nxt[7:TRC_HIGH_LSB] = wbDatIn[7:TRC_HIGH_LSB];
         end
         if (!armed_r) begin
            trace_nxt[TRC_LOW_WIDTH-1:0] = wbDatIn[TRC_LOW_WIDTH-1:0];
         end
      end else if (wbWr && (wbAdr == {REG_CTRL_IDX[7:0], 2'b00})) begin
         armed_nxt = wbDatIn[CTRL_ARM_BIT];
      end
      if (wbReq && !wbWe) begin
         if (wbAdr == {REG_CTRL_IDX[7:0], 2'b00}) begin
            wbDat_nxt[CTRL_ARM_BIT] = armed_r;
         end else if (wbAdr == {REG_STAT_IDX[7:0], 2'b00}) begin
            wbDat_nxt[STAT_ARM_BIT] = armed_r;
            wbDat_nxt[2:0] = seq_r;
         end else if (wbAdr == {REG_TRACE_IDX[7:0], 2'b00}) begin
            wbDat_nxt[7:0] = trace_r;
         end
      end
      if (!armed_nxt) begin
         seq_nxt = SEQ_DISARMED;
      end else if (seq_r == SEQ_DISARMED) begin
         seq_nxt = SEQ_STATE1;
      end else if (seqStep && (seq_r == SEQ_STATE3)) begin
         seq_nxt = SEQ_FINAL;
      end else if (seqStep && (seq_r != SEQ_FINAL)) begin
         seq_nxt = seq_r + 3'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         trace_r <= TRACE_RST;
         armed_r <= 1'b0;
         seq_r <= SEQ_DISARMED;
         wbDatOut <= 32'h0000_0000;
         wbAck <= 1'b0;
         modeNormal <= 1'b0;
         modeSuppress <= 1'b0;
         modeDetail <= 1'b0;
         alignBegin <= 1'b0;
         alignMiddle <= 1'b0;
         alignEnd <= 1'b0;
         cmpSeqTrigger <= 1'b0;
      end else begin
         trace_r <= trace_nxt;
         armed_r <= armed_nxt;
         seq_r <= seq_nxt;
         wbDatOut <= wbDat_nxt;
         wbAck <= wbAck_nxt;
         modeNormal <= (trace_nxt.mode == MODE_NORMAL);
         modeSuppress <= (trace_nxt.mode == MODE_SUPPRESS);
         modeDetail <= (trace_nxt.mode == MODE_DETAIL);
         alignBegin <= (trace_nxt.align == ALIGN_BEGIN);
         alignMiddle <= (trace_nxt.align == ALIGN_MIDDLE);
         alignEnd <= (trace_nxt.align == ALIGN_END);
         cmpSeqTrigger <= cmpHit && compareEnable;
      end
   end
   assign traceCfg = trace_r;
   assign seqState = seq_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_enable_write;
      @(posedge ref_clk) disable iff (rst)
      hostCmd.valid && (hostCmd.kind == CMD_WRITE_STATUS) && !startup_r
      |=> debugEnable == $past(hostCmd.data[STAT_ENABLE_BIT]);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable bit not loaded");

   property p_active_needs_enable;
      @(posedge ref_clk) disable iff (rst)
      $rose(debugActive) |-> debugEnable;
   endproperty
   a_active_needs_enable: assert property (p_active_needs_enable) else $error("active unenabled");

   property p_fw_accept;
      @(posedge ref_clk) disable iff (rst)
      fwCmdAccept |-> $past(debugActive) && $past(fwCmdValid);
   endproperty
   a_fw_accept: assert property (p_fw_accept) else $error("firmware command taken idle");

   property p_boundary;
      @(posedge ref_clk) disable iff (rst)
      (state_r == ST_WAIT) && instrDone && (boundLeft_r == 2'h1)
      |=> debugActive && fwFetchStart ##1 !fwFetchStart;
   endproperty
   a_boundary: assert property (p_boundary) else $error("no entry at boundary");

   property p_force_late;
      @(posedge ref_clk) disable iff (rst)
      (state_r == ST_WAIT) && (boundLeft_r == 2'h2) && instrDone
      |=> !debugActive && (state_r == ST_WAIT);
   endproperty
   a_force_late: assert property (p_force_late) else $error("force entered early");

   property p_hold_time;
      @(posedge ref_clk) disable iff (rst)
      $rose(cpuHold) |-> cpuHold [*5] ##1 !cpuHold && !debugActive;
   endproperty
   a_hold_time: assert property (p_hold_time) else $error("hold length wrong");

   property p_host_bg_dropped;
      @(posedge ref_clk) disable iff (rst)
      hostBg && !cpuReq && !enable_r && (state_r == ST_IDLE) && !startup_r
      |=> !cpuHold && (state_r == ST_IDLE);
   endproperty
   a_host_bg_dropped: assert property (p_host_bg_dropped) else $error("background not dropped");

   property p_map;
      @(posedge ref_clk) disable iff (rst)
      regWindowHit |-> $past(debugActive) && ($past(cpuAddr) <= DBG_REG_LAST);
   endproperty
   a_map: assert property (p_map) else $error("window hit outside range");

   property p_startup;
      @(posedge ref_clk) disable iff (rst)
      startup_r && specialChip |=> debugActive && debugEnable;
   endproperty
   a_startup: assert property (p_startup) else $error("special reset not active");

   property p_seq_code;
      @(posedge ref_clk) disable iff (rst)
      (seqState <= SEQ_FINAL) && (armed_r || (seqState == SEQ_DISARMED));
   endproperty
   a_seq_code: assert property (p_seq_code) else $error("reserved sequencer code");

   property p_trace_lock;
      @(posedge ref_clk) disable iff (rst)
      wbWr && (wbAdr == {REG_TRACE_IDX[7:0], 2'b00}) && armed_r |=> $stable(traceCfg);
   endproperty
   a_trace_lock: assert property (p_trace_lock) else $error("trace written while armed");

   property p_secure_source;
      @(posedge ref_clk) disable iff (rst)
      $rose(traceCfg.source) |-> !$past(secured);
   endproperty
   a_secure_source: assert property (p_secure_source) else $error("source set secured");
endmodule

//--- verif/dbgme_host_model.sv
// Behavioural debug host that issues single-wire commands to the device.
module dbgme_host_model (
   // Clock.
   input wire logic ref_clk,
   // Command to the device.
   output dbgme_pkg::dbgme_cmd_t hostCmd
);
   timeunit 1ns;
   timeprecision 1ps;
   import dbgme_pkg::*;
   initial hostCmd = '0;
   // Between commands the fields carry the inverse of the last ones, never a held value.
   task automatic send(input logic [1:0] kind, input logic [7:0] data, input int gap);
      repeat (gap) @(posedge ref_clk);
      @(posedge ref_clk);
      hostCmd <= '{valid: 1'b1, kind: kind, data: data};
      @(posedge ref_clk);
      hostCmd <= '{valid: 1'b0, kind: ~kind, data: ~data};
   endtask
endmodule

//--- verif/debug_mode_entry_and_trace_control_tb_top.sv
// Self-checking testbench of the debug entry and trace control block.
module debug_mode_entry_and_trace_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dbgme_pkg::*;
   // ----------------------------------------------------------------
   // Design and partner
   // ----------------------------------------------------------------
   localparam logic [1:0] MN = 2'h3, MS = 2'h0, MD = 2'h1, AB = 2'h1, AM = 2'h3, AE = 2'h0;
   localparam logic [9:0] A_CTL = REG_CTRL_IDX << 2;
   localparam logic [9:0] A_STS = REG_STAT_IDX << 2;
   localparam logic [9:0] A_TRC = REG_TRACE_IDX << 2;
   logic ref_clk, rst, wbCyc, wbStb, wbWe, wbAck, specialChip, secured, instrDone, dbgExit;
   logic cpuHold, fwFetchStart, debugActive, debugEnable, fwCmdAccept, regWindowHit, tableHit;
   logic seqTrigger, cmpHit, compareEnable, cmpSeqTrigger, modeNormal, modeSuppress, fwCmdValid;
   logic modeDetail, alignBegin, alignMiddle, alignEnd;
   logic [9:0] wbAdr;
   logic [3:0] wbSel, srcPulse, dbgRdAddr;
   logic [31:0] wbDatIn, wbDatOut, rd;
   logic [7:0] dbgRdData, trc;
   logic [22:0] cpuAddr;
   logic [2:0] seqState;
   dbgme_cmd_t hostCmd;
   dbgme_trace_t traceCfg;
   int miscompares = 0;
   int nTests = 0;
   dbgme_core #(.MODE_NORMAL(MN), .MODE_SUPPRESS(MS), .MODE_DETAIL(MD), .ALIGN_BEGIN(AB),
      .ALIGN_MIDDLE(AM), .ALIGN_END(AE)) u_dbgme_core (
      .ref_clk(ref_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
      .hostCmd(hostCmd), .specialChip(specialChip), .secured(secured),
      .cpuEnterDbg(srcPulse[0]), .extTag(srcPulse[1]), .bkptTag(srcPulse[2]),
      .bkptForce(srcPulse[3]), .instrDone(instrDone), .dbgExit(dbgExit), .cpuHold(cpuHold),
      .fwFetchStart(fwFetchStart), .debugActive(debugActive), .debugEnable(debugEnable),
      .fwCmdValid(fwCmdValid), .fwCmdAccept(fwCmdAccept), .dbgRdAddr(dbgRdAddr),
      .dbgRdData(dbgRdData), .cpuAddr(cpuAddr), .regWindowHit(regWindowHit),
      .tableHit(tableHit), .seqTrigger(seqTrigger), .cmpHit(cmpHit),
      .compareEnable(compareEnable), .traceCfg(traceCfg), .modeNormal(modeNormal),
      .modeSuppress(modeSuppress), .modeDetail(modeDetail), .alignBegin(alignBegin),
      .alignMiddle(alignMiddle), .alignEnd(alignEnd), .cmpSeqTrigger(cmpSeqTrigger),
      .seqState(seqState));
   dbgme_host_model u_dbgme_host_model (.ref_clk(ref_clk), .hostCmd(hostCmd));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ----------------------------------------------------------------
   // Tasks and expectations
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nTests++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   function automatic logic [5:0] expDec(input logic [7:0] t);
      return {t[3:2] == MN, t[3:2] == MS, t[3:2] == MD, t[1:0] == AB, t[1:0] == AM,
         t[1:0] == AE};
   endfunction
   function automatic logic [1:0] expHit(input logic [22:0] a, input logic act);
      return {act && a >= DBG_WIN_BASE && a <= DBG_REG_LAST, act && a > DBG_REG_LAST};
   endfunction
   // One classic Wishbone cycle; the request stands until ack is sampled high.
   task automatic wbXfer(input logic we, input logic [9:0] a, input logic [7:0] d,
      input logic [3:0] s, output logic [31:0] q);
      @(posedge ref_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbSel <= s;
      wbDatIn <= ({$urandom} << 8) | 32'(d);
      do begin
         @(posedge ref_clk);
      end while (wbAck !== 1'b1);
      chk("wbAck", 1, wbAck);
      q = wbDatOut;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   task automatic doReset(input logic sc);
      @(posedge ref_clk);
      specialChip <= sc;
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
   endtask
   task automatic decodeChk(input logic act);
      logic [22:0] a;
      logic fv;
      for (int i = 0; i < 6; i++) begin
         a = 23'h7ffe00 + 23'($urandom_range(0, 511));
         if (i < 2) a = DBG_REG_LAST + 23'(i);
         fv = (i == 5) || 1'($urandom);
         @(posedge ref_clk);
         cpuAddr <= a;
         fwCmdValid <= fv;
         @(posedge ref_clk);
         #1 chk("windowHit", expHit(a, act), {regWindowHit, tableHit});
         chk("acceptDec", fv && act, fwCmdAccept);
      end
   endtask
   task automatic fire(input int k);
      if (k == 4) begin
         u_dbgme_host_model.send(CMD_BACKGROUND, 8'($urandom), 0);
      end else begin
         @(posedge ref_clk);
         srcPulse <= 4'(1 << k);
         @(posedge ref_clk);
         srcPulse <= 4'h0;
      end
   endtask
   task automatic holdCheck(input int k);
      int hi;
      hi = 0;
      fire(k);
      repeat (8) begin
         #1 hi += cpuHold;
         @(posedge ref_clk);
      end
      chk("holdCycles", (k == 4) ? 0 : HOLD_CYCLES, hi);
      chk("idleActive", 0, debugActive);
   endtask
   task automatic activate(input int k);
      fire(k);
      #1 chk("acceptIdle", 0, fwCmdAccept);
      repeat ((k == 3) ? 2 : 1) begin
         chk("activeEarly", 0, debugActive);
         @(posedge ref_clk);
         instrDone <= 1'b1;
         @(posedge ref_clk);
         instrDone <= 1'b0;
         #1;
      end
      chk("active", 1, debugActive);
      chk("fwStart", 1, fwFetchStart);
      @(posedge ref_clk);
      #1 chk("fwStartOnce", 0, fwFetchStart);
      chk("accept", 1, fwCmdAccept);
      chk("statusDbg", 8'hc0, dbgRdData);
      decodeChk(1'b1);
      @(posedge ref_clk);
      dbgExit <= 1'b1;
      @(posedge ref_clk);
      dbgExit <= 1'b0;
      #1 chk("exit", 0, debugActive);
   endtask
   task automatic traceRound(input int r);
      logic arm, sec;
      logic [3:0] s;
      logic [7:0] v;
      logic [5:0] dec;
      int k, st;
      arm = (r == 2) || (r > 2 && 1'($urandom));
      sec = (r == 0) || (r > 2 && 1'($urandom));
      v = (r == 0) ? 8'h7f : (r == 1) ? 8'h40 : 8'($urandom) & 8'h7f;
      s = (r < 3) ? 4'h1 : 4'($urandom);
      @(posedge ref_clk);
      secured <= sec;
      wbXfer(1'b1, A_CTL, {7'h0, arm}, 4'hf, rd);
      wbXfer(1'b1, A_TRC, v, s, rd);
      if (s[0] && !arm) trc[5:0] = v[5:0];
      if (s[0] && !arm && !sec) trc[7:6] = v[7:6];
      wbXfer(1'b0, A_TRC, 8'h00, 4'hf, rd);
      chk("trace", trc, rd);
      chk("traceCfg", trc, traceCfg);
      dec = {modeNormal, modeSuppress, modeDetail, alignBegin, alignMiddle, alignEnd};
      chk("decode", expDec(trc), dec);
      wbXfer(1'b0, A_STS, 8'h00, 4'hf, rd);
      st = arm;
      chk("status", {arm, 3'(st)}, rd);
      repeat (5) begin
         k = $urandom_range(0, 2);
         @(posedge ref_clk);
         seqTrigger <= (k == 0);
         cmpHit <= (k != 0);
         compareEnable <= (k == 1);
         @(posedge ref_clk);
         seqTrigger <= 1'b0;
         cmpHit <= 1'b0;
         if (arm && k != 2 && st < 4) st++;
         #1 chk("cmpSeq", k == 1, cmpSeqTrigger);
         chk("seqState", st, seqState);
      end
      wbXfer(1'b0, A_CTL, 8'h00, 4'hf, rd);
      chk("ctrl", {7'h0, arm}, rd);
      wbXfer(1'b1, A_CTL, 8'h00, 4'hf, rd);
      @(posedge ref_clk);
      #1 chk("disarmed", SEQ_DISARMED, seqState);
   endtask
   // ----------------------------------------------------------------
   // Test sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {wbCyc, wbStb, wbWe, specialChip, secured, instrDone, dbgExit} = '0;
      {seqTrigger, cmpHit, compareEnable} = '0;
      fwCmdValid = 1'b1;
      {wbAdr, wbSel, srcPulse, dbgRdAddr, wbDatIn, cpuAddr} = '0;
      trc = TRACE_RST;
      void'($urandom(59697));
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      #1 chk("resetOut", 0, {cpuHold, fwFetchStart, debugActive, debugEnable});
      wbXfer(1'b0, A_TRC, 8'h00, 4'hf, rd);
      chk("traceReset", TRACE_RST, rd);
      decodeChk(1'b0);
      $display("test reset done");
      for (int k = 0; k < 5; k++) holdCheck(k);
      $display("test unenabled attempts done");
      for (int r = 0; r < 12; r++) traceRound(r);
      wbXfer(1'b0, 10'h3fc, 8'h00, 4'hf, rd);
      chk("unmapped", 0, rd);
      $display("test trace control done");
      u_dbgme_host_model.send(CMD_WRITE_STATUS, 8'h80, $urandom_range(0, 3));
      #1 chk("enable", 1, debugEnable);
      @(posedge ref_clk);
      dbgRdAddr <= {DBG_STATUS_OFF};
      @(posedge ref_clk);
      #1 chk("statusEn", 8'h80, dbgRdData);
      wbXfer(1'b0, {4'h0, DBG_STATUS_OFF, 2'h0}, 8'h00, 4'hf, rd);
      chk("userRead", 0, rd);
      for (int k = 0; k < 5; k++) activate(k);
      u_dbgme_host_model.send(CMD_WRITE_STATUS, 8'h00, 1);
      #1 chk("disable", 0, debugEnable);
      $display("test activation done");
      doReset(1'b1);
      @(posedge ref_clk);
      #1 chk("special", 3'h7, {debugActive, debugEnable, fwFetchStart});
      $display("test special reset done");
      results();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      results();
   end
endmodule
